// ===== logic/twm_pkg.sv
// Purpose: constants and types of the two-wire master task/event layer
// Assumes: 32-bit Avalon-MM register port, byte addresses
// Notes: Function list below
// Function
// - Writing 1 to start_receive_trigger begins a receive sequence.
// - Writing 1 to start_transmit_trigger begins a transmit; reads zero.
// - After pause request, finish current byte, then set paused_flag.
// - Once paused, bus stays halted until continue is triggered.
package twm_pkg;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [11:0] OFS_START_RX = 12'h000;
	localparam logic [11:0] OFS_START_TX = 12'h008;
	localparam logic [11:0] OFS_HALT = 12'h014;
	localparam logic [11:0] OFS_PAUSE = 12'h01C;
	localparam logic [11:0] OFS_CONTINUE = 12'h020;
	localparam logic [11:0] OFS_EV_HALTED = 12'h104;
	localparam logic [11:0] OFS_EV_FAULT = 12'h124;
	localparam logic [11:0] OFS_EV_PAUSED = 12'h148;
	localparam logic [11:0] OFS_EV_RXBEGUN = 12'h14C;
	localparam logic [11:0] OFS_IRQ_STATUS = 12'h310;
	localparam logic [11:0] OFS_IRQ_ENABLE = 12'h314;
	localparam logic [11:0] OFS_IRQ_CLEAR = 12'h318;
	// ----------------------------------------
	// Fields and reset values
	// ----------------------------------------
	localparam int FLAG_BIT = 0;
	localparam int NUM_EV = 4;
	localparam int EV_HALTED = 0;
	localparam int EV_FAULT = 1;
	localparam int EV_PAUSED = 2;
	localparam int EV_RXBEGUN = 3;
	localparam logic [3:0] EV_RESET = 4'h0;
	localparam logic [3:0] IRQ_EN_RESET = 4'h0;
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
	// SCL rising edges per byte: eight data bits and acknowledge
	localparam logic [3:0] BITS_PER_BYTE = 4'h9;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic rd;
		logic wr;
		logic [11:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} twm_bus_req_type;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RUN,
		ST_PAUSING,
		ST_PAUSED,
		ST_STOPPING
	} twm_state_type;
endpackage

// ===== logic/twm_bus_port.sv
// Purpose: Avalon-MM handshake with one wait cycle per access
// Assumes: master holds request until waitrequest is low
// Notes: take_o marks the edge at which the access completes
`timescale 1ns/1ns
module twm_bus_port import twm_pkg::*; (
	input wire logic sys_clk_i, // System clock
	input wire logic reset_i, // Async reset, high
	input wire twm_bus_req_type req_i, // Bus request
	output logic wait_o, // Waitrequest, registered
	output logic load_o, // Load read data now
	output logic take_o // Access completes now
);
	logic wait_q;
	logic wait_d;
	wire req_any = req_i.rd | req_i.wr;
	assign wait_d = ~(req_any & wait_q);
	assign load_o = req_i.rd & wait_q;
	assign take_o = req_any & ~wait_q;
	assign wait_o = wait_q;
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) wait_q <= 1'b1;
		else wait_q <= wait_d;
	end
endmodule // twm_bus_port

// ===== logic/twm_link_edge.sv
// Purpose: two-stage sync of the link clock pin and rise detect
// Assumes: link clock far slower than sys_clk_i
// Notes: first stage feeds only the second
`timescale 1ns/1ns
module twm_link_edge (
	input wire logic sys_clk_i, // System clock
	input wire logic reset_i, // Async reset, high
	input wire logic pin_i, // Raw link clock pin
	output logic rise_o // One-cycle pulse per rising edge
);
	logic meta_q;
	logic sync_q;
	logic last_q;
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			meta_q <= 1'b1;
			sync_q <= 1'b1;
			last_q <= 1'b1;
		end else begin
			meta_q <= pin_i;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end
	assign rise_o = sync_q & ~last_q;
endmodule // twm_link_edge

// ===== logic/twm_task_event.sv
// Purpose: task triggers, event flags and pause control of a two-wire master
// Assumes: framer reports stop and error as one-cycle pulses on sys_clk_i
// Notes: bytes are found by counting synced SCL rising edges
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ns
module twm_task_event import twm_pkg::*; (
	input wire logic sys_clk_i, // 250 MHz system clock
	input wire logic reset_i, // Async reset, high
	input wire logic [11:0] avs_address_i, // Byte address
	input wire logic avs_read_i, // Read request
	input wire logic avs_write_i, // Write request
	input wire logic [3:0] avs_byteenable_i, // Byte lanes
	input wire logic [31:0] avs_writedata_i, // Write data
	output logic [31:0] avs_readdata_o, // Read data
	output logic avs_waitrequest_o, // Wait request
	output logic irq_o, // Level interrupt
	input wire logic scl_i, // Link clock pin
	input wire logic stopped_i, // Framer stop done pulse
	input wire logic error_i, // Framer error pulse
	output logic start_rx_o, // Start receive pulse
	output logic start_tx_o, // Start transmit pulse
	output logic stop_o, // Request stop pulse
	output logic hold_o // Freeze bus while paused
);
	// ----------------------------------------
	// Bus port
	// ----------------------------------------
	twm_bus_req_type req;
	logic load;
	logic take;
	assign req = '{rd: avs_read_i, wr: avs_write_i, addr: avs_address_i,
		be: avs_byteenable_i, wdata: avs_writedata_i};
	twm_bus_port u_port (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.req_i(req),
		.wait_o(avs_waitrequest_o),
		.load_o(load),
		.take_o(take)
	);
	function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
		return a[11:2] == ofs[11:2];
	endfunction
	// ----------------------------------------
	// Write decode
	// ----------------------------------------
	wire wr_lane0 = take & req.wr & req.be[0];
	wire wr_one = wr_lane0 & req.wdata[FLAG_BIT];
	wire task_rx = wr_one & hit(req.addr, OFS_START_RX);
	wire task_tx = wr_one & hit(req.addr, OFS_START_TX);
	wire task_halt = wr_one & hit(req.addr, OFS_HALT);
	wire task_pause = wr_one & hit(req.addr, OFS_PAUSE);
	wire task_cont = wr_one & hit(req.addr, OFS_CONTINUE);
	wire wr_zero = wr_lane0 & ~req.wdata[FLAG_BIT];
	logic [NUM_EV-1:0] ev_zero;
	assign ev_zero[EV_HALTED] = wr_zero & hit(req.addr, OFS_EV_HALTED);
	assign ev_zero[EV_FAULT] = wr_zero & hit(req.addr, OFS_EV_FAULT);
	assign ev_zero[EV_PAUSED] = wr_zero & hit(req.addr, OFS_EV_PAUSED);
	assign ev_zero[EV_RXBEGUN] = wr_zero & hit(req.addr, OFS_EV_RXBEGUN);
	wire wr_en_reg = take & req.wr & req.be[0] & hit(req.addr, OFS_IRQ_ENABLE);
	wire wr_clr_reg = take & req.wr & req.be[0] & hit(req.addr, OFS_IRQ_CLEAR);
	// ----------------------------------------
	// Byte boundary tracking
	// ----------------------------------------
	logic scl_rise;
	twm_link_edge u_edge (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.pin_i(scl_i),
		.rise_o(scl_rise)
	);
	twm_state_type state_q;
	twm_state_type state_d;
	logic [3:0] bit_q;
	logic [3:0] bit_d;
	logic start_rx_d;
	logic start_tx_d;
	logic stop_d;
	wire moving = (state_q == ST_RUN) || (state_q == ST_PAUSING);
	wire byte_done = moving & scl_rise & (bit_q == BITS_PER_BYTE - 4'h1);
	// Idle between bytes counts as a boundary too
	wire at_boundary = byte_done | ((bit_q == 4'h0) & ~scl_rise);
	always_comb begin
		bit_d = bit_q;
		if (start_rx_d | start_tx_d) bit_d = 4'h0;
		else if (byte_done) bit_d = 4'h0;
		else if (moving & scl_rise) bit_d = bit_q + 4'h1;
	end
	// ----------------------------------------
	// Task sequencer
	// ----------------------------------------
	always_comb begin
		state_d = state_q;
		start_rx_d = 1'b0;
		start_tx_d = 1'b0;
		stop_d = 1'b0;
		case (state_q)
			ST_IDLE: begin
				if (task_rx) begin
					start_rx_d = 1'b1;
					state_d = ST_RUN;
				end else if (task_tx) begin
					start_tx_d = 1'b1;
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (task_halt) begin
					stop_d = 1'b1;
					state_d = ST_STOPPING;
				end else if (task_pause) state_d = ST_PAUSING;
			end
			ST_PAUSING: begin
				if (task_halt) begin
					stop_d = 1'b1;
					state_d = ST_STOPPING;
				end else if (at_boundary) state_d = ST_PAUSED;
			end
			ST_PAUSED: begin
				// Halt is ignored here: it must come after continue
				if (task_cont) state_d = ST_RUN;
			end
			ST_STOPPING: begin
				if (stopped_i) state_d = ST_IDLE;
			end
			default: state_d = ST_IDLE;
		endcase
		// Framer may end the frame at any time
		if (stopped_i) state_d = ST_IDLE;
	end
	// ----------------------------------------
	// Event flags and interrupt
	// ----------------------------------------
	logic [NUM_EV-1:0] ev_q;
	logic [NUM_EV-1:0] ev_d;
	logic [NUM_EV-1:0] ev_set;
	logic [NUM_EV-1:0] en_q;
	logic [NUM_EV-1:0] en_d;
	logic [NUM_EV-1:0] ev_clr;
	assign ev_set[EV_HALTED] = stopped_i;
	assign ev_set[EV_FAULT] = error_i;
	assign ev_set[EV_PAUSED] = (state_q == ST_PAUSING) && (state_d == ST_PAUSED);
	assign ev_set[EV_RXBEGUN] = start_rx_d;
	assign ev_clr = ev_zero | (wr_clr_reg ? req.wdata[NUM_EV-1:0] : '0);
	// Set wins over a clear in the same cycle
	assign ev_d = (ev_q & ~ev_clr) | ev_set;
	assign en_d = wr_en_reg ? req.wdata[NUM_EV-1:0] : en_q;
	wire irq_d = |(ev_d & en_d);
	// ----------------------------------------
	// Read decode
	// ----------------------------------------
	logic [31:0] rdata_d;
	always_comb begin
		rdata_d = RDATA_RESET;
		if (hit(req.addr, OFS_EV_HALTED)) rdata_d[FLAG_BIT] = ev_q[EV_HALTED];
		else if (hit(req.addr, OFS_EV_FAULT)) rdata_d[FLAG_BIT] = ev_q[EV_FAULT];
		else if (hit(req.addr, OFS_EV_PAUSED)) rdata_d[FLAG_BIT] = ev_q[EV_PAUSED];
		else if (hit(req.addr, OFS_EV_RXBEGUN)) rdata_d[FLAG_BIT] = ev_q[EV_RXBEGUN];
		else if (hit(req.addr, OFS_IRQ_STATUS)) rdata_d[NUM_EV-1:0] = ev_q;
		else if (hit(req.addr, OFS_IRQ_ENABLE)) rdata_d[NUM_EV-1:0] = en_q;
		// Task and clear registers are write-only and read zero
	end
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [31:0] rdata_q;
	logic start_rx_q;
	logic start_tx_q;
	logic stop_q;
	logic hold_q;
	logic irq_q;
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_q <= ST_IDLE;
			bit_q <= 4'h0;
			ev_q <= EV_RESET;
			en_q <= IRQ_EN_RESET;
			rdata_q <= RDATA_RESET;
			start_rx_q <= 1'b0;
			start_tx_q <= 1'b0;
			stop_q <= 1'b0;
			hold_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			state_q <= state_d;
			bit_q <= bit_d;
			ev_q <= ev_d;
			en_q <= en_d;
			if (load) rdata_q <= rdata_d;
			start_rx_q <= start_rx_d;
			start_tx_q <= start_tx_d;
			stop_q <= stop_d;
			hold_q <= (state_d == ST_PAUSED);
			irq_q <= irq_d;
		end
	end
	assign avs_readdata_o = rdata_q;
	assign start_rx_o = start_rx_q;
	assign start_tx_o = start_tx_q;
	assign stop_o = stop_q;
	assign hold_o = hold_q;
	assign irq_o = irq_q;
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);
	sequence s_byte_ends;
		(state_q == ST_PAUSING) && byte_done && !task_halt && !stopped_i;
	endsequence
	sequence s_now_paused;
		(state_q == ST_PAUSED) && ev_q[EV_PAUSED] && hold_q;
	endsequence
	property p_rx_start;
		(state_q == ST_IDLE) && task_rx && !stopped_i |=> start_rx_q && ev_q[EV_RXBEGUN] ##1 !start_rx_q;
	endproperty
	a_rx_start: assert property (p_rx_start) else $error("receive start missing");
	property p_tx_start;
		(state_q == ST_IDLE) && task_tx && !task_rx && !stopped_i |=> start_tx_q && (state_q == ST_RUN);
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("transmit start missing");
	property p_tx_reads_zero;
		load && hit(req.addr, OFS_START_TX) |=> avs_readdata_o == 32'h0000_0000;
	endproperty
	a_tx_reads_zero: assert property (p_tx_reads_zero) else $error("task register read nonzero");
	property p_pause_at_byte;
		s_byte_ends |=> s_now_paused;
	endproperty
	a_pause_at_byte: assert property (p_pause_at_byte) else $error("pause not taken at byte end");
	property p_no_early_pause;
		(state_q == ST_PAUSING) && (bit_q != 4'h0) && !byte_done |=> (state_q != ST_PAUSED);
	endproperty
	a_no_early_pause: assert property (p_no_early_pause) else $error("paused inside a byte");
	property p_stay_paused;
		(state_q == ST_PAUSED) && !task_cont && !stopped_i |=> hold_q && !start_rx_q && !stop_q
			&& (bit_q == $past(bit_q));
	endproperty
	a_stay_paused: assert property (p_stay_paused) else $error("bus moved while paused");
	property p_resume;
		(state_q == ST_PAUSED) && task_cont && !stopped_i |=> !hold_q [*2];
	endproperty
	a_resume: assert property (p_resume) else $error("continue did not release bus");
	property p_flag_clear;
		ev_zero[EV_FAULT] && !error_i && !wr_clr_reg |=> !ev_q[EV_FAULT];
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("fault flag not cleared");
	property p_flag_sticky;
		ev_q[EV_HALTED] && !ev_clr[EV_HALTED] |=> ev_q[EV_HALTED];
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("halted flag lost");
	property p_irq;
		|(ev_q & en_q) |-> ##[0:1] irq_o;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt not raised");
	// ----------------------------------------
	// Bus, task and event checks
	// ----------------------------------------
	property p_req_waits;
		(avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
	endproperty
	a_req_waits: assert property (p_req_waits) else $error("request not answered after one wait");
	property p_wait_one;
		!avs_waitrequest_o |=> avs_waitrequest_o;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("waitrequest low for more than one cycle");
	property p_rx_flag_cause;
		$rose(ev_q[EV_RXBEGUN]) |-> start_rx_q;
	endproperty
	a_rx_flag_cause: assert property (p_rx_flag_cause) else $error("receive flag without start");
	property p_no_start_busy;
		(state_q != ST_IDLE) && (task_rx || task_tx) |=> !start_rx_q && !start_tx_q;
	endproperty
	a_no_start_busy: assert property (p_no_start_busy) else $error("start taken while busy");
	property p_tx_pulse;
		start_tx_q |=> !start_tx_q;
	endproperty
	a_tx_pulse: assert property (p_tx_pulse) else $error("transmit start longer than one cycle");
	property p_pause_enter;
		(state_q == ST_RUN) && task_pause && !task_halt && !stopped_i |=> (state_q == ST_PAUSING) && !hold_q;
	endproperty
	a_pause_enter: assert property (p_pause_enter) else $error("pause request not taken");
	property p_pause_flag_hold;
		$rose(hold_q) |-> ev_q[EV_PAUSED] && (state_q == ST_PAUSED);
	endproperty
	a_pause_flag_hold: assert property (p_pause_flag_hold) else $error("bus held without paused flag");
	property p_cont_run;
		(state_q == ST_PAUSED) && task_cont && !stopped_i |=> (state_q == ST_RUN);
	endproperty
	a_cont_run: assert property (p_cont_run) else $error("continue did not resume");
	property p_halt_ignored;
		(state_q == ST_PAUSED) && task_halt && !stopped_i |=> !stop_q && (state_q == ST_PAUSED);
	endproperty
	a_halt_ignored: assert property (p_halt_ignored) else $error("halt acted while paused");
	property p_stop_done;
		stopped_i |=> (state_q == ST_IDLE) && ev_q[EV_HALTED];
	endproperty
	a_stop_done: assert property (p_stop_done) else $error("stop done not recorded");
	property p_fault_set;
		error_i |=> ev_q[EV_FAULT];
	endproperty
	a_fault_set: assert property (p_fault_set) else $error("fault flag not set");
	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	// Flag indices and status bits must fit one word
	if (NUM_EV > 32 || EV_RXBEGUN >= NUM_EV || FLAG_BIT > 31) begin : g_bad_flags
		$error("event layout does not fit the register word");
	end
	if (BITS_PER_BYTE < 4'h2) begin : g_bad_byte
		$error("byte length too short for the boundary counter");
	end
endmodule // twm_task_event

// ===== dv/twm_link_model.sv
// Purpose: far side of the two-wire link: bus clock and framer pulses
// Assumes: sys_clk_i at 250 MHz, bus clock period 40 cycles (160 ns)
// Notes: bus clock idles high (pull-up) and stands still outside frames
`timescale 1ns/1ns
module twm_link_model (
	input wire logic sys_clk_i, // System clock
	input wire logic reset_i, // Async reset, high
	input wire logic start_i, // Frame start pulse
	input wire logic stop_i, // Stop request pulse
	input wire logic hold_i, // Bus frozen while high
	input wire logic fault_i, // Bench asks for a bus error
	output logic scl_o, // Link clock pin
	output logic stopped_o, // Stop done pulse
	output logic error_o // Bus error pulse
);
	logic run_q;
	logic [4:0] div_q;
	logic [3:0] stp_q;
	// ----------------------------------------
	// Frame and clock generation
	// ----------------------------------------
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			run_q <= 1'b0;
			div_q <= 5'h00;
			stp_q <= 4'h0;
			scl_o <= 1'b1;
			stopped_o <= 1'b0;
			error_o <= 1'b0;
		end else begin
			error_o <= fault_i;
			stopped_o <= (stp_q == 4'h1);
			if (stp_q != 4'h0)
				stp_q <= stp_q - 4'h1;
			if (stop_i)
				stp_q <= 4'h6;
			if (stp_q == 4'h1) begin
				run_q <= 1'b0;
				scl_o <= 1'b1;
			end else if (start_i) begin
				run_q <= 1'b1;
				div_q <= 5'h00;
				scl_o <= 1'b0;
			end else if (run_q && !hold_i) begin
				// Clock stretched while held, like a slave holding the line
				div_q <= (div_q == 5'h13) ? 5'h00 : div_q + 5'h01;
				if (div_q == 5'h13)
					scl_o <= ~scl_o;
			end
		end
	end
endmodule // twm_link_model

// ===== dv/two_wire_master_task_event_control_tb_top.sv
// Purpose: self-checking bench of the task and event layer
// Assumes: master waits for waitrequest low, link model on the far side
// Notes: pulses are counted by monitors, checked after the access ends
`timescale 1ns/1ns
module two_wire_master_task_event_control_tb_top;
	import twm_pkg::*;
	logic clk = 1'b0, rst = 1'b1, rd_q = 1'b0, wr_q = 1'b0, fault = 1'b0, scl_d = 1'b1;
	logic [11:0] addr = 12'h000;
	logic [3:0] be = 4'hF;
	logic [31:0] wd = 32'h0000_0000, rdata;
	logic waitreq, irq, scl, stopped, error, srx, stx, stp, hold;
	int mismatches = 0, tests_run = 0, n_rx = 0, n_tx = 0, n_stop = 0, rises = 0, n;
	logic [11:0] ofs [11] = '{OFS_START_RX, OFS_START_TX, OFS_HALT, OFS_PAUSE, OFS_CONTINUE, OFS_EV_HALTED,
		OFS_EV_FAULT, OFS_EV_PAUSED, OFS_EV_RXBEGUN, OFS_IRQ_STATUS, 12'h400};
	always #2 clk = ~clk;
	twm_task_event u_twm_task_event (.sys_clk_i(clk), .reset_i(rst), .avs_address_i(addr), .avs_read_i(rd_q),
		.avs_write_i(wr_q), .avs_byteenable_i(be), .avs_writedata_i(wd), .avs_readdata_o(rdata),
		.avs_waitrequest_o(waitreq), .irq_o(irq), .scl_i(scl), .stopped_i(stopped), .error_i(error),
		.start_rx_o(srx), .start_tx_o(stx), .stop_o(stp), .hold_o(hold));
	twm_link_model u_twm_link_model (.sys_clk_i(clk), .reset_i(rst), .start_i(srx | stx), .stop_i(stp),
		.hold_i(hold), .fault_i(fault), .scl_o(scl), .stopped_o(stopped), .error_o(error));
	// ----------------------------------------
	// Monitors
	// ----------------------------------------
	always @(posedge clk) begin
		n_rx <= n_rx + (srx === 1'b1);
		n_tx <= n_tx + (stx === 1'b1);
		n_stop <= n_stop + (stp === 1'b1);
		scl_d <= scl;
		if (srx === 1'b1 || stx === 1'b1)
			rises <= 0;
		else if (scl === 1'b1 && scl_d === 1'b0)
			rises <= rises + 1;
	end
	// ----------------------------------------
	// Checks and bus tasks
	// ----------------------------------------
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Holds the request until waitrequest is seen low at a rising edge
	task automatic access(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr_q <= w;
		rd_q <= ~w;
		do @(posedge clk); while (waitreq !== 1'b0);
		q = rdata;
		wr_q <= 1'b0;
		rd_q <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		access(1'b1, a, d, q);
	endtask
	task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] q;
		access(1'b0, a, 32'h0000_0000, q);
		check(nm, q, exp);
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		final_report();
	end
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		foreach (ofs[i]) rchk("reset value", ofs[i], 32'h0000_0000);
		rchk("irq enable reset", OFS_IRQ_ENABLE, 32'h0000_0000);
		wr(OFS_START_RX, 32'h0000_0000);
		wr(OFS_START_RX, 32'h0000_0001);
		rchk("receive begun", OFS_EV_RXBEGUN, 32'h0000_0001);
		check("rx pulses", n_rx, 1);
		fault <= 1'b1;
		@(posedge clk);
		fault <= 1'b0;
		rchk("fault flag", OFS_EV_FAULT, 32'h0000_0001);
		wr(OFS_IRQ_ENABLE, 32'h0000_0002);
		repeat (2) @(posedge clk);
		check("irq enabled", irq, 1'b1);
		wr(OFS_IRQ_ENABLE, 32'h0000_0000);
		repeat (2) @(posedge clk);
		check("irq masked", irq, 1'b0);
		wr(OFS_IRQ_CLEAR, 32'h0000_0002);
		rchk("fault cleared", OFS_EV_FAULT, 32'h0000_0000);
		check("no auto stop", n_stop, 0);
		wr(OFS_EV_RXBEGUN, 32'h0000_0001);
		rchk("write one no effect", OFS_EV_RXBEGUN, 32'h0000_0001);
		wr(OFS_EV_RXBEGUN, 32'h0000_0000);
		rchk("write zero clears", OFS_EV_RXBEGUN, 32'h0000_0000);
		wr(OFS_HALT, 32'h0000_0001);
		repeat (20) @(posedge clk);
		rchk("halted flag", OFS_EV_HALTED, 32'h0000_0001);
		wr(OFS_EV_HALTED, 32'h0000_0000);
		be <= 4'h0;
		wr(OFS_START_TX, 32'h0000_0001);
		be <= 4'hF;
		repeat (2) @(posedge clk);
		check("tx lane refused", n_tx, 0);
		wr(OFS_START_TX, 32'h0000_0001);
		rchk("tx reads zero", OFS_START_TX, 32'h0000_0000);
		check("tx pulses", n_tx, 1);
		n = 0;
		while (rises < 3 && n < 2000) begin
			@(posedge clk);
			n++;
		end
		wr(OFS_PAUSE, 32'h0000_0001);
		n = 0;
		while (hold !== 1'b1 && n < 2000) begin
			@(posedge clk);
			n++;
		end
		check("rises at pause", rises, 9);
		rchk("paused flag", OFS_EV_PAUSED, 32'h0000_0001);
		wr(OFS_IRQ_ENABLE, 32'h0000_0004);
		repeat (2) @(posedge clk);
		check("irq paused", irq, 1'b1);
		repeat (200) @(posedge clk);
		check("still held", hold, 1'b1);
		check("no traffic", rises, 9);
		wr(OFS_HALT, 32'h0000_0001);
		repeat (20) @(posedge clk);
		check("halt while paused", n_stop, 1);
		wr(OFS_CONTINUE, 32'h0000_0001);
		repeat (3) @(posedge clk);
		check("released", hold, 1'b0);
		repeat (60) @(posedge clk);
		check("traffic again", rises, 10);
		wr(OFS_HALT, 32'h0000_0001);
		repeat (20) @(posedge clk);
		check("stop after continue", n_stop, 2);
		rchk("status", OFS_IRQ_STATUS, 32'h0000_0005);
		final_report();
	end
endmodule // two_wire_master_task_event_control_tb_top
